// [hdl/rsrb_defines.svh]
// register offsets, reset values and timing constants for the radio register bank
`ifndef RSRB_DEFINES_SVH
`define RSRB_DEFINES_SVH
`define RSRB_ADDR_REVISION   6'h00
`define RSRB_ADDR_CONTROL    6'h03
`define RSRB_ADDR_RATE       6'h04
`define RSRB_ADDR_CONFIG     6'h05
`define RSRB_ADDR_SERIAL     6'h06
`define RSRB_ADDR_RX_IRQ_EN  6'h07
`define RSRB_ADDR_RX_FLAGS   6'h08
`define RSRB_ADDR_RX_BYTE_A  6'h09
`define RSRB_ADDR_RX_VAL_A   6'h0a
`define RSRB_ADDR_RX_BYTE_B  6'h0b
`define RSRB_ADDR_RX_VAL_B   6'h0c
`define RSRB_ADDR_TX_IRQ_EN  6'h0d
`define RSRB_ADDR_TX_FLAGS   6'h0e
`define RSRB_ADDR_TX_BYTE    6'h0f
`define RSRB_ADDR_TX_VALID   6'h10
`define RSRB_ADDR_CODE_LO    6'h11
`define RSRB_ADDR_CODE_HI    6'h18
`define RSRB_ADDR_THRESH_LO  6'h19
`define RSRB_ADDR_THRESH_HI  6'h1a
`define RSRB_ADDR_WAKE_EN    6'h1c
`define RSRB_ADDR_WAKE_STAT  6'h1d
`define RSRB_ADDR_ANALOG     6'h20
`define RSRB_ADDR_CHANNEL    6'h21
`define RSRB_ADDR_STRENGTH   6'h22
`define RSRB_ADDR_AMP_BIAS   6'h23
`define RSRB_ADDR_XTAL_TRIM  6'h24
`define RSRB_ADDR_VCO_CAL    6'h26
`define RSRB_ADDR_POWER      6'h2e
`define RSRB_ADDR_SENSE      6'h2f
`define RSRB_ADDR_CLK_MAN    6'h32
`define RSRB_ADDR_CLK_EN     6'h33
`define RSRB_ADDR_SETTLE     6'h38
`define RSRB_ADDR_SERNUM_LO  6'h3c
`define RSRB_ADDR_SERNUM_HI  6'h3f
`define RSRB_DEF_CONFIG      8'h01
`define RSRB_DEF_SERIAL      8'h03
`define RSRB_DEF_THRESH_LO   8'h08
`define RSRB_DEF_THRESH_HI   8'h38
`define RSRB_DEF_WAKE_STAT   1'b1
`define RSRB_DEF_ANALOG      8'h04
`define RSRB_DEF_SETTLE      8'h64
`define RSRB_DEF_CODE        64'h1e8b6a3de0e9b222
`define RSRB_CMD_WRITE_BIT   7
`define RSRB_CMD_INC_BIT     6
`define RSRB_CTL_RX_BIT      7
`define RSRB_CTL_TX_BIT      6
`define RSRB_CTL_HALF_BIT    5
`define RSRB_CTL_BYPASS_BIT  4
`define RSRB_CTL_AMPMODE_BIT 3
`define RSRB_CTL_AMPSW_BIT   2
`define RSRB_RATE_WIDTH_BIT  2
`define RSRB_CLK_PERIOD_NS   25
`define RSRB_SETTLE_UNIT_NS  2000
`define RSRB_UNIT_CYCLES     (`RSRB_SETTLE_UNIT_NS / `RSRB_CLK_PERIOD_NS)
`endif

// [hdl/rsrb_pkg.sv]
// types shared by the radio register bank
package rsrb_pkg;
    // host access phase inside one select frame
    typedef enum logic [0:0] {
        RSRB_PH_CMD  = 1'b0,
        RSRB_PH_DATA = 1'b1
    } rsrb_phase_t;
    // synthesizer settle sequencer
    typedef enum logic [1:0] {
        RSRB_ST_IDLE  = 2'b00,
        RSRB_ST_LOCK  = 2'b01,
        RSRB_ST_COUNT = 2'b10
    } rsrb_settle_t;
    // read-only values that the radio core reports
    typedef struct packed {
        logic [7:0] rxIrqFlags;
        logic [7:0] rxByteA;
        logic [7:0] rxValidA;
        logic [7:0] rxByteB;
        logic [7:0] rxValidB;
        logic [7:0] txIrqFlags;
        logic [7:0] signalStrength;
    } rsrb_status_t;
endpackage : rsrb_pkg

// [hdl/rsrb_register_bank.sv]
// register bank of the radio modem with byte-level host access and settle sequencer
`timescale 1ns/1ps
`include "rsrb_defines.svh"
module rsrb_register_bank
    import rsrb_pkg::*;
#(
    parameter bit          TX_ONLY      = 1'b0,
    parameter logic [3:0]  SILICON_REV  = 4'h0,
    parameter logic [3:0]  PRODUCT_CODE = 4'h5,          // arbitrary value
    parameter logic [31:0] SERIAL_NUM   = 32'h1234_5678  // arbitrary value
)(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         frameActive,
    input  wire logic         byteValid,
    input  wire logic [7:0]   byteIn,
    output logic              readValid,
    output logic [7:0]        readByte,
    input  wire rsrb_status_t coreStatus,
    input  wire logic         wakeEvent,
    input  wire logic         settleStart,
    input  wire logic         synthLock,
    input  wire logic         basebandAmpRequest,
    output logic              rxEnable,
    output logic              txEnable,
    output logic              codeHalfUpper,
    output logic              amplifierOn,
    output logic              wakeFlag,
    output logic              settleDone
);

    logic [7:0]   regFile [0:63];
    rsrb_phase_t  phase;
    logic         dirWrite;
    logic         autoInc;
    logic [5:0]   addr;
    logic [5:0]   stepAddr;
    logic [5:0]   fetchAddr;
    logic         cmdTaken;
    logic         dataTaken;
    logic         readFetch;
    logic         writeNow;
    logic [7:0]   readMux;
    rsrb_settle_t settleState;
    logic [6:0]   unitCount;
    logic [7:0]   unitsLeft;

    // reset value of a stored register
    function automatic logic [7:0] defaultOf(input logic [5:0] a);
        logic [5:0] idx;
        idx = a - `RSRB_ADDR_CODE_LO;
        if (a >= `RSRB_ADDR_CODE_LO && a <= `RSRB_ADDR_CODE_HI) begin
            return 8'(`RSRB_DEF_CODE >> {idx[2:0], 3'h0});
        end
        unique case (a)
            `RSRB_ADDR_CONFIG:    return `RSRB_DEF_CONFIG;
            `RSRB_ADDR_SERIAL:    return `RSRB_DEF_SERIAL;
            `RSRB_ADDR_THRESH_LO: return `RSRB_DEF_THRESH_LO;
            `RSRB_ADDR_THRESH_HI: return `RSRB_DEF_THRESH_HI;
            `RSRB_ADDR_ANALOG:    return `RSRB_DEF_ANALOG;
            `RSRB_ADDR_SETTLE:    return `RSRB_DEF_SETTLE;
            default:              return 8'h00;
        endcase
    endfunction : defaultOf

    // receive-only registers, dead in the transmit-only variant
    function automatic logic isRxReg(input logic [5:0] a);
        return (a >= `RSRB_ADDR_RX_IRQ_EN && a <= `RSRB_ADDR_RX_VAL_B) ||
               a == `RSRB_ADDR_THRESH_LO || a == `RSRB_ADDR_THRESH_HI ||
               a == `RSRB_ADDR_STRENGTH;
    endfunction : isRxReg

    // host-writable registers; read-only and unmapped ones are not stored
    function automatic logic isWritable(input logic [5:0] a);
        logic rw;
        rw = 1'b0;
        unique case (a)
            `RSRB_ADDR_CONTROL, `RSRB_ADDR_RATE, `RSRB_ADDR_CONFIG, `RSRB_ADDR_SERIAL,
            `RSRB_ADDR_RX_IRQ_EN, `RSRB_ADDR_TX_IRQ_EN, `RSRB_ADDR_TX_BYTE, `RSRB_ADDR_TX_VALID,
            `RSRB_ADDR_THRESH_LO, `RSRB_ADDR_THRESH_HI, `RSRB_ADDR_WAKE_EN, `RSRB_ADDR_ANALOG,
            `RSRB_ADDR_CHANNEL, `RSRB_ADDR_AMP_BIAS, `RSRB_ADDR_XTAL_TRIM, `RSRB_ADDR_VCO_CAL,
            `RSRB_ADDR_POWER, `RSRB_ADDR_SENSE, `RSRB_ADDR_CLK_MAN, `RSRB_ADDR_CLK_EN,
            `RSRB_ADDR_SETTLE: rw = 1'b1;
            default:           rw = (a >= `RSRB_ADDR_CODE_LO && a <= `RSRB_ADDR_CODE_HI);
        endcase
        return rw && !(TX_ONLY && isRxReg(a));
    endfunction : isWritable

    // command and data byte decode within a select frame
    assign cmdTaken  = frameActive && byteValid && phase == RSRB_PH_CMD;
    assign dataTaken = frameActive && byteValid && phase == RSRB_PH_DATA;
    assign stepAddr  = autoInc ? addr + 6'h01 : addr;
    assign writeNow  = dataTaken && dirWrite;
    assign readFetch = (cmdTaken && !byteIn[`RSRB_CMD_WRITE_BIT]) || (dataTaken && !dirWrite);
    assign fetchAddr = cmdTaken ? byteIn[5:0] : stepAddr;

    // frame phase and address pointer; a dropped select always restarts at a command byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase    <= RSRB_PH_CMD;
            dirWrite <= 1'b0;
            autoInc  <= 1'b0;
            addr     <= 6'h00;
        end else if (!frameActive) begin
            phase <= RSRB_PH_CMD;
        end else if (cmdTaken) begin
            phase    <= RSRB_PH_DATA;
            dirWrite <= byteIn[`RSRB_CMD_WRITE_BIT];
            autoInc  <= byteIn[`RSRB_CMD_INC_BIT];
            addr     <= byteIn[5:0];
        end else if (dataTaken) begin
            addr <= stepAddr;
        end
    end

    // stored registers; writes to read-only or unmapped addresses fall away
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 64; i++) begin
                regFile[i] <= defaultOf(6'(i));
            end
        end else if (writeNow && isWritable(addr)) begin
            regFile[addr] <= byteIn;
        end
    end

    // read value for the fetched address
    always_comb begin
        readMux = 8'h00;
        if (fetchAddr == `RSRB_ADDR_REVISION) begin
            readMux = {SILICON_REV, PRODUCT_CODE};
        end else if (fetchAddr >= `RSRB_ADDR_SERNUM_LO) begin
            readMux = 8'(SERIAL_NUM >> {fetchAddr[1:0], 3'h0});
        end else if (TX_ONLY && isRxReg(fetchAddr)) begin
            readMux = 8'h00;
        end else begin
            unique case (fetchAddr)
                `RSRB_ADDR_RX_FLAGS:  readMux = coreStatus.rxIrqFlags;
                `RSRB_ADDR_RX_BYTE_A: readMux = coreStatus.rxByteA;
                `RSRB_ADDR_RX_VAL_A:  readMux = coreStatus.rxValidA;
                `RSRB_ADDR_RX_BYTE_B: readMux = coreStatus.rxByteB;
                `RSRB_ADDR_RX_VAL_B:  readMux = coreStatus.rxValidB;
                `RSRB_ADDR_TX_FLAGS:  readMux = coreStatus.txIrqFlags;
                `RSRB_ADDR_STRENGTH:  readMux = coreStatus.signalStrength;
                `RSRB_ADDR_WAKE_STAT: readMux = {7'h00, wakeFlag};
                default:              readMux = isWritable(fetchAddr) ? regFile[fetchAddr] : 8'h00;
            endcase
        end
    end

    // read answer, one cycle after the byte that asks for it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readValid <= 1'b0;
            readByte  <= 8'h00;
        end else begin
            readValid <= readFetch;
            if (readFetch) begin
                readByte <= readMux;
            end
        end
    end

    // wake flag: a wake event landing on the clearing read still wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wakeFlag <= `RSRB_DEF_WAKE_STAT;
        end else if (wakeEvent) begin
            wakeFlag <= 1'b1;
        end else if (readFetch && fetchAddr == `RSRB_ADDR_WAKE_STAT) begin
            wakeFlag <= 1'b0;
        end
    end

    // control outputs, registered so the core sees clean levels
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxEnable      <= 1'b0;
            txEnable      <= 1'b0;
            codeHalfUpper <= 1'b0;
            amplifierOn   <= 1'b0;
        end else begin
            rxEnable      <= regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_RX_BIT];
            txEnable      <= regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_TX_BIT];
            // half select is meaningless for 64-chip codes, so it is forced low there
            codeHalfUpper <= regFile[`RSRB_ADDR_RATE][`RSRB_RATE_WIDTH_BIT] &&
                             regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_HALF_BIT];
            amplifierOn   <= regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_AMPMODE_BIT]
                           ? regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_AMPSW_BIT]
                           : basebandAmpRequest;
        end
    end

    // settle sequencer: optional lock wait, then the programmed count of 2 us units
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settleState <= RSRB_ST_IDLE;
            unitCount   <= 7'h00;
            unitsLeft   <= 8'h00;
            settleDone  <= 1'b0;
        end else begin
            settleDone <= 1'b0;
            unique case (settleState)
                RSRB_ST_IDLE: begin
                    if (settleStart) begin
                        unitCount   <= 7'h00;
                        unitsLeft   <= regFile[`RSRB_ADDR_SETTLE];
                        settleState <= regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_BYPASS_BIT]
                                     ? RSRB_ST_COUNT : RSRB_ST_LOCK;
                    end
                end
                RSRB_ST_LOCK: begin
                    // the count is sampled at start; a later write takes effect next time
                    if (synthLock) begin
                        settleState <= RSRB_ST_COUNT;
                    end
                end
                RSRB_ST_COUNT: begin
                    if (unitsLeft == 8'h00) begin
                        settleDone  <= 1'b1;
                        settleState <= RSRB_ST_IDLE;
                    end else if (unitCount == 7'(`RSRB_UNIT_CYCLES - 1)) begin
                        unitCount <= 7'h00;
                        unitsLeft <= unitsLeft - 8'h01;
                    end else begin
                        unitCount <= unitCount + 7'h01;
                    end
                end
                default: settleState <= RSRB_ST_IDLE;
            endcase
        end
    end

    // checks on the control path, host access, wake flag and settle sequencer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence ctrlWrite;
        writeNow && addr == `RSRB_ADDR_CONTROL;
    endsequence

    sequence lockPending;
        settleState == RSRB_ST_LOCK && !synthLock;
    endsequence

    rx_enable_a: assert property (ctrlWrite ##2 1'b1 |-> rxEnable == $past(byteIn[`RSRB_CTL_RX_BIT], 2))
        else $error("receive enable does not follow control write");
    tx_enable_a: assert property (ctrlWrite ##2 1'b1 |-> txEnable == $past(byteIn[`RSRB_CTL_TX_BIT], 2))
        else $error("transmit enable does not follow control write");
    half_select_a: assert property (##1 !regFile[`RSRB_ADDR_RATE][`RSRB_RATE_WIDTH_BIT] |=> !codeHalfUpper)
        else $error("half select active with 64-chip codes");
    half_upper_a: assert property (regFile[`RSRB_ADDR_RATE][`RSRB_RATE_WIDTH_BIT] &&
                                   regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_HALF_BIT]
                                   |=> codeHalfUpper)
        else $error("upper half not selected");
    amp_source_a: assert property (!regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_AMPMODE_BIT]
                                   |=> amplifierOn == $past(basebandAmpRequest))
        else $error("amplifier not following baseband");
    rev_read_a: assert property (readFetch && fetchAddr == `RSRB_ADDR_REVISION
                                 |=> readValid && readByte == {SILICON_REV, PRODUCT_CODE})
        else $error("revision register read wrong");
    wake_clear_a: assert property (readFetch && fetchAddr == `RSRB_ADDR_WAKE_STAT && !wakeEvent
                                   |=> !wakeFlag)
        else $error("wake flag not cleared by read");
    wake_set_a: assert property (wakeEvent |=> wakeFlag)
        else $error("wake event lost");
    lock_hold_a: assert property (lockPending |=> settleState == RSRB_ST_LOCK)
        else $error("settle left lock wait without lock");
    bypass_skip_a: assert property (settleState == RSRB_ST_IDLE && settleStart &&
                                    regFile[`RSRB_ADDR_CONTROL][`RSRB_CTL_BYPASS_BIT]
                                    |=> settleState == RSRB_ST_COUNT)
        else $error("lock bypass not honoured");
    ro_write_a: assert property (writeNow && addr == `RSRB_ADDR_WAKE_STAT && !wakeEvent && !readFetch
                                 |=> wakeFlag == $past(wakeFlag))
        else $error("write altered a read-only flag");

endmodule : rsrb_register_bank

// [test/rsrb_host_model.sv]
// host microcontroller model driving the byte-level select frame
`timescale 1ns/1ps
module rsrb_host_model (
    input  wire logic       clk,
    input  wire logic       readValid,
    input  wire logic [7:0] readByte,
    output logic            frameActive,
    output logic            byteValid,
    output logic [7:0]      byteIn
);
    initial begin
        frameActive = 1'b0;
        byteValid   = 1'b0;
        byteIn      = 8'h00;
    end
    // dropping the frame ends a burst, so the next byte is a command again
    task automatic frame(input logic on);
        @(negedge clk);
        frameActive = on;
    endtask : frame
    // byte held across one rising edge; released data is inverted so a stale value never matches
    task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic got);
        got = 1'b0;
        r   = 8'h00;
        @(negedge clk);
        byteValid = 1'b1;
        byteIn    = b;
        for (int i = 0; i < 3; i++) begin
            @(negedge clk);
            byteValid = 1'b0;
            byteIn    = ~b;
            if (!got && readValid === 1'b1) begin
                got = 1'b1;
                r   = readByte;
            end
        end
    endtask : xfer
    // command byte: write flag on top, then increment flag, then six-bit address
    task automatic access(input logic wr, input logic inc, input logic [5:0] a,
                          output logic [7:0] r, output logic got);
        xfer({wr, inc, a}, r, got);
    endtask : access
endmodule : rsrb_host_model

// [test/test_rsrb_register_bank.sv]
// self-checking bench for the radio register bank
`timescale 1ns/1ps
`include "rsrb_defines.svh"
module test_rsrb_register_bank
    import rsrb_pkg::*;
;
    localparam logic [3:0]  SIL_REV = 4'h2;         // arbitrary value
    localparam logic [3:0]  PROD    = 4'h9;         // arbitrary value
    localparam logic [31:0] SER     = 32'ha1b2c3d4; // arbitrary value
    localparam int          UNIT    = `RSRB_UNIT_CYCLES;
    logic         clk = 1'b0;
    logic         resetn = 1'b0;
    logic         frameActive, byteValid, readValid, rxEnable, txEnable;
    logic         codeHalfUpper, amplifierOn, wakeFlag, settleDone;
    logic         wakeEvent = 1'b0, settleStart = 1'b0, synthLock = 1'b0, basebandAmpRequest = 1'b0;
    logic [7:0]   byteIn, readByte, readByteTx;
    rsrb_status_t coreStatus = 56'h11_22_33_44_55_66_77;
    int           numErrors = 0, testsRun = 0;

    always #12.5 clk = ~clk;

    rsrb_register_bank #(.TX_ONLY(1'b0), .SILICON_REV(SIL_REV), .PRODUCT_CODE(PROD), .SERIAL_NUM(SER)) u_dut (
        .clk(clk), .resetn(resetn), .frameActive(frameActive), .byteValid(byteValid), .byteIn(byteIn),
        .readValid(readValid), .readByte(readByte), .coreStatus(coreStatus), .wakeEvent(wakeEvent),
        .settleStart(settleStart), .synthLock(synthLock), .basebandAmpRequest(basebandAmpRequest),
        .rxEnable(rxEnable), .txEnable(txEnable), .codeHalfUpper(codeHalfUpper),
        .amplifierOn(amplifierOn), .wakeFlag(wakeFlag), .settleDone(settleDone));

    // transmit-only variant listens to the same byte stream; only its read data is judged
    rsrb_register_bank #(.TX_ONLY(1'b1), .SILICON_REV(SIL_REV), .PRODUCT_CODE(PROD), .SERIAL_NUM(SER)) u_dut_tx (
        .clk(clk), .resetn(resetn), .frameActive(frameActive), .byteValid(byteValid), .byteIn(byteIn),
        .readValid(), .readByte(readByteTx), .coreStatus(coreStatus), .wakeEvent(wakeEvent),
        .settleStart(settleStart), .synthLock(synthLock), .basebandAmpRequest(basebandAmpRequest),
        .rxEnable(), .txEnable(), .codeHalfUpper(), .amplifierOn(), .wakeFlag(), .settleDone());

    rsrb_host_model u_host (
        .clk(clk), .readValid(readValid), .readByte(readByte),
        .frameActive(frameActive), .byteValid(byteValid), .byteIn(byteIn));

    task automatic complete_run();
        $display("errors %0d checks %0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    // a missing answer is fatal to the run, so stop at once
    task automatic no_answer();
        numErrors++;
        complete_run();
    endtask : no_answer
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit
    // burst read of n bytes, lowest byte of exp first
    task automatic rd(input logic [5:0] a, input logic inc, input int n, input logic [63:0] exp);
        logic [7:0] r;
        logic       got;
        u_host.frame(1'b1);
        u_host.access(1'b0, inc, a, r, got);
        for (int k = 0; k < n; k++) begin
            if (k > 0) u_host.xfer(8'h00, r, got);
            if (got !== 1'b1) no_answer();
            check_byte(r, exp[8*k +: 8]);
        end
        u_host.frame(1'b0);
    endtask : rd
    task automatic wr(input logic [5:0] a, input logic inc, input int n, input logic [63:0] d);
        logic [7:0] r;
        logic       got;
        u_host.frame(1'b1);
        u_host.access(1'b1, inc, a, r, got);
        check_bit(got, 1'b0);
        for (int k = 0; k < n; k++) u_host.xfer(d[8*k +: 8], r, got);
        u_host.frame(1'b0);
    endtask : wr
    // counts falling edges until the settle pulse, bounded
    task automatic wait_done(output int n);
        n = 0;
        while (settleDone !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 30 * UNIT) no_answer();
        end
    endtask : wait_done

    task automatic t_defaults();
        logic [5:0] a[8] = '{6'h03, 6'h04, 6'h05, 6'h06, 6'h19, 6'h1a, 6'h20, 6'h38};
        logic [7:0] v[8] = '{8'h00, 8'h00, 8'h01, 8'h03, 8'h08, 8'h38, 8'h04, 8'h64};
        for (int i = 0; i < 8; i++) rd(a[i], 1'b0, 1, {56'h0, v[i]});
        rd(6'h11, 1'b1, 8, `RSRB_DEF_CODE);
    endtask : t_defaults

    // read-only places keep their contents through writes; unmapped reads give zero
    task automatic t_readonly();
        for (int p = 0; p < 2; p++) begin
            rd(6'h00, 1'b0, 1, {56'h0, SIL_REV, PROD});
            check_byte(readByteTx, {SIL_REV, PROD});
            rd(6'h3c, 1'b1, 4, {32'h0, SER});
            rd(6'h08, 1'b0, 1, 64'h11);
            check_byte(readByteTx, 8'h00);
            rd(6'h09, 1'b1, 4, 64'h55443322);
            rd(6'h0e, 1'b0, 1, 64'h66);
            rd(6'h22, 1'b0, 1, 64'h77);
            check_byte(readByteTx, 8'h00);
            rd(6'h1d, 1'b0, 1, 64'h00);
            rd(6'h01, 1'b0, 1, 64'h00);
            wr(6'h1d, 1'b0, 1, 64'hff);
            wr(6'h00, 1'b0, 1, 64'hff);
            wr(6'h3c, 1'b1, 4, 64'hffffffff);
            wr(6'h08, 1'b0, 1, 64'hee);
            wr(6'h22, 1'b0, 1, 64'hee);
            wr(6'h01, 1'b0, 1, 64'h5a);
        end
    endtask : t_readonly

    task automatic t_readwrite();
        wr(6'h0f, 1'b1, 2, 64'h5aa5);
        rd(6'h0f, 1'b1, 2, 64'h5aa5);
        wr(6'h21, 1'b0, 2, 64'h3412);
        rd(6'h21, 1'b0, 2, 64'h3434);
        wr(6'h11, 1'b1, 8, 64'h0123456789abcdef);
        rd(6'h11, 1'b1, 8, 64'h0123456789abcdef);
    endtask : t_readwrite

    // entry: control byte, code width bit, baseband request, expected rx tx half amp
    task automatic t_control();
        logic [13:0] t[8] = '{{8'hc0, 2'b00, 4'b1100}, {8'h20, 2'b01, 4'b0001}, {8'h20, 2'b10, 4'b0010},
                              {8'h0c, 2'b10, 4'b0001}, {8'h08, 2'b01, 4'b0000}, {8'h80, 2'b00, 4'b1000},
                              {8'h40, 2'b00, 4'b0100}, {8'h00, 2'b00, 4'b0000}};
        for (int i = 0; i < 8; i++) begin
            basebandAmpRequest = t[i][4];
            wr(6'h04, 1'b0, 1, {61'h0, t[i][5], 2'b00});
            wr(6'h03, 1'b0, 1, {56'h0, t[i][13:6]});
            check_bit(rxEnable, t[i][3]);
            check_bit(txEnable, t[i][2]);
            check_bit(codeHalfUpper, t[i][1]);
            check_bit(amplifierOn, t[i][0]);
        end
        basebandAmpRequest = 1'b1;
        wr(6'h03, 1'b0, 1, 64'h00);
        check_bit(amplifierOn, 1'b1);
        basebandAmpRequest = 1'b0;
        @(negedge clk);
        @(negedge clk);
        check_bit(amplifierOn, 1'b0);
    endtask : t_control

    // one unit behind the lock bypass, then the advised count behind the lock wait
    task automatic t_settle();
        int n;
        int cnt;
        for (int b = 1; b >= 0; b--) begin
            cnt = b ? 1 : 25;
            wr(6'h38, 1'b0, 1, 64'(cnt));
            wr(6'h03, 1'b0, 1, b ? 64'h10 : 64'h00);
            @(negedge clk);
            settleStart = 1'b1;
            @(negedge clk);
            settleStart = 1'b0;
            if (b == 0) begin
                // no pulse may come while lock is still missing
                for (int i = 0; i < 2 * UNIT; i++) begin
                    @(negedge clk);
                    check_bit(settleDone, 1'b0);
                end
                synthLock = 1'b1;
            end
            wait_done(n);
            check_bit(n >= cnt * UNIT - 2 && n <= cnt * UNIT + 6, 1'b1);
            synthLock = 1'b0;
        end
    endtask : t_settle

    task automatic t_wake();
        check_bit(wakeFlag, 1'b1);
        rd(6'h1d, 1'b0, 1, 64'h01);
        check_bit(wakeFlag, 1'b0);
        rd(6'h1d, 1'b0, 1, 64'h00);
        @(negedge clk);
        wakeEvent = 1'b1;
        @(negedge clk);
        wakeEvent = 1'b0;
        @(negedge clk);
        check_bit(wakeFlag, 1'b1);
        rd(6'h1d, 1'b0, 1, 64'h01);
    endtask : t_wake

    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        t_wake();
        t_defaults();
        t_readonly();
        t_readwrite();
        t_control();
        t_settle();
        complete_run();
    end
endmodule : test_rsrb_register_bank
